// File: rtl/pdm_pkg.sv
// Package for the port D pin mux, input routing and read-back block
package pdm_pkg;

	// ********************************************************************
	// Register map (byte addresses on the register bus)
	// ********************************************************************
	localparam logic [7:0] ADDR_FUNC_SEL_LOW  = 8'h00;
	localparam logic [7:0] ADDR_FUNC_SEL_HIGH = 8'h04;
	localparam logic [7:0] ADDR_SRC_SEL_A     = 8'h08;
	localparam logic [7:0] ADDR_SRC_SEL_B     = 8'h0C;
	localparam logic [7:0] ADDR_SRC_SEL_C     = 8'h10;
	localparam logic [7:0] ADDR_SRC_SEL_D     = 8'h14;
	localparam logic [7:0] ADDR_UNLOCK        = 8'h18;
	localparam logic [7:0] REG_RESET          = 8'h00;

	// ********************************************************************
	// Field positions (low bit of each two-bit field, or the single SDA and SCL bits) and codes
	// ********************************************************************
	localparam int F_HI  = 6;
	localparam int F_MH  = 4;
	localparam int F_ML  = 2;
	localparam int F_LO  = 0;
	localparam int F_SDA = 7;
	localparam int F_SCL = 6;
	localparam logic [1:0] CODE_00 = 2'h0;
	localparam logic [1:0] CODE_01 = 2'h1;
	localparam logic [1:0] CODE_10 = 2'h2;
	localparam logic [1:0] CODE_11 = 2'h3;

	// Pattern that opens the read-back self-test mode
	localparam logic [7:0] UNLOCK_KEY = 8'hCA;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Number of converter input channels with an analog switch
	localparam int AN_CHANNELS = 10;

	// ********************************************************************
	// Whole state of the block
	// ********************************************************************
	typedef struct packed {
		logic [7:0]  func_sel_low;
		logic [7:0]  func_sel_high;
		logic [7:0]  src_a;
		logic [7:0]  src_b;
		logic [7:0]  src_c;
		logic [7:0]  src_d;
		logic [7:0]  unlock;
		logic        read_port_enable;
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [7:0]  w_data;
		logic        w_strb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
		logic [4:1]  pd_out;
		logic [4:1]  pd_oe;
		logic [2:0]  hall_in;
		logic        capture_timer_in;
		logic        sda_in;
		logic        scl_in;
		logic        serial_rx_in;
		logic        noise_filter_in;
		logic        ext_irq_in;
		logic [3:0]  timer_cap_in;
		logic [3:0]  timer_clk_in;
		logic [7:0]  read_data;
		logic [AN_CHANNELS-1:0] an_switch;
	} pdm_state_t;

endpackage

// File: rtl/pdm_top.sv
// Port D pin mux, peripheral input routing and read-back self-test logic
//
// Behaviour
// - First select bits 7:6 pick port_d3 function
// - First select bits 5:4 pick port_d2 function
// - First select bits 3:2 pick port_d1 function
// - Second select bits 1:0 pick port_d4 function
// - Source A bits 7:6 route hall_in3
// - Source A bits 5:4 route hall_in2
// - Source A bits 3:2 route hall_in1
// - Source A bits 1:0 route capture_timer_in
// - Source B bits 7,6 route SDA, SCL
// - Source B bits 5:4 route serial input
// - Source B bits 3:2 route noise_filter_in
// - Source B bits 1:0 route ext_irq_in
// - Source C routes timer_cap_in0 and timer_cap_in1
// - Source C routes timer_cap_in2 and timer_cap_in3
// - Source D routes timer_clk_in0 and timer_clk_in1
// - Source D routes timer_clk_in2 and timer_clk_in3
// - Key byte sets read_port_enable, others clear
// - Enabled: port read returns pin levels
// - Disabled: latch, pin level, or zero for analog/blocked
// - Read mode touches only the read path and the converter switches
// - Enabled mode forces selected converter switch closed
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module pdm_top (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Register bus, write address and data
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// Register bus, write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Register bus, read
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Pin levels
	input  wire logic [7:0]  port_a_in,
	input  wire logic [7:0]  port_b_in,
	input  wire logic [4:1]  port_d_in,
	// Port D general purpose drive and peripheral outputs
	input  wire logic [4:1]  gpio_d_out,
	input  wire logic [4:1]  gpio_d_oe,
	input  wire logic        timer_out0,
	input  wire logic        timer_out1,
	input  wire logic        timer_out1_n,
	input  wire logic        timer_out2_n,
	input  wire logic        hall_out_a,
	input  wire logic        hall_out_b,
	input  wire logic        hall_out_c,
	input  wire logic        gate_a_low,
	input  wire logic        gate_a_high,
	input  wire logic        gate_b_high,
	input  wire logic        serial_out,
	input  wire logic        serial_oe,
	// Port D pin drive
	output logic [4:1]       pd_out,
	output logic [4:1]       pd_oe,
	// Routed peripheral inputs
	output logic             hall_in1,
	output logic             hall_in2,
	output logic             hall_in3,
	output logic             capture_timer_in,
	output logic             sda_in,
	output logic             scl_in,
	output logic             serial_rx_in,
	output logic             noise_filter_in,
	output logic             ext_irq_in,
	output logic [3:0]       timer_cap_in,
	output logic [3:0]       timer_clk_in,
	// Port read-back path for the port being read
	input  wire logic [7:0]  rd_pin_level,
	input  wire logic [7:0]  rd_data_latch,
	input  wire logic [7:0]  rd_port_ctrl,
	input  wire logic [7:0]  rd_is_analog,
	input  wire logic [7:0]  rd_is_dig_out,
	output logic [7:0]       read_data,
	output logic             read_port_enable,
	// Converter analog input switches
	input  wire logic [3:0]  adc_channel_sel,
	input  wire logic [9:0]  an_func_sel,
	output logic [9:0]       an_switch
);

	// ********************************************************************
	// State and helpers
	// ********************************************************************
	pdm_pkg::pdm_state_t s;
	pdm_pkg::pdm_state_t next_s;
	logic       aw_fire, w_fire, ar_fire, wr_go, wr_strb, wr_hit;
	logic [7:0] wr_addr, wr_byte;
	logic [8:0] rd_hit_data;
	logic [1:0] d3_sel, d2_sel, d1_sel, d4_sel;
	logic       d1_gpio, d2_gpio, d3_gpio, d4_gpio, d1_serial;
	// Pick one of four sources; reserved slots are fed a constant low
	function automatic logic route4(input logic [1:0] sel, input logic c0, input logic c1,
		input logic c2, input logic c3);
		logic r;
		case (sel)
			pdm_pkg::CODE_00: r = c0;
			pdm_pkg::CODE_01: r = c1;
			pdm_pkg::CODE_10: r = c2;
			default:          r = c3;
		endcase
		return r;
	endfunction
	// Address decode for reads: {hit, byte}
	function automatic logic [8:0] reg_read(input pdm_pkg::pdm_state_t st, input logic [7:0] a);
		logic [8:0] r;
		case (a)
			pdm_pkg::ADDR_FUNC_SEL_LOW:  r = {1'b1, st.func_sel_low};
			pdm_pkg::ADDR_FUNC_SEL_HIGH: r = {1'b1, st.func_sel_high};
			pdm_pkg::ADDR_SRC_SEL_A:     r = {1'b1, st.src_a};
			pdm_pkg::ADDR_SRC_SEL_B:     r = {1'b1, st.src_b};
			pdm_pkg::ADDR_SRC_SEL_C:     r = {1'b1, st.src_c};
			pdm_pkg::ADDR_SRC_SEL_D:     r = {1'b1, st.src_d};
			pdm_pkg::ADDR_UNLOCK:        r = {1'b1, st.unlock};
			default:                     r = 9'h000;
		endcase
		return r;
	endfunction
	// Bus handshakes; a held half waits for its partner, then the answer blocks new ones
	assign awready     = !s.aw_held && !s.bvalid;
	assign wready      = !s.w_held && !s.bvalid;
	assign arready     = !s.rvalid;
	assign aw_fire     = awvalid && awready;
	assign w_fire      = wvalid && wready;
	assign ar_fire     = arvalid && arready;
	assign wr_go       = (s.aw_held || aw_fire) && (s.w_held || w_fire);
	assign wr_addr     = s.aw_held ? s.aw_addr : awaddr[7:0];
	assign wr_byte     = s.w_held ? s.w_data : wdata[7:0];
	assign wr_strb     = s.w_held ? s.w_strb0 : wstrb[0];
	assign wr_hit      = reg_read(s, wr_addr) >> 8 != 9'h000;
	assign rd_hit_data = reg_read(s, araddr[7:0]);
	// Current pin functions of port D
	assign d3_sel    = s.func_sel_low[pdm_pkg::F_HI +: 2];
	assign d2_sel    = s.func_sel_low[pdm_pkg::F_MH +: 2];
	assign d1_sel    = s.func_sel_low[pdm_pkg::F_ML +: 2];
	assign d4_sel    = s.func_sel_high[pdm_pkg::F_LO +: 2];
	assign d1_gpio   = d1_sel == pdm_pkg::CODE_00;
	assign d2_gpio   = d2_sel == pdm_pkg::CODE_00;
	assign d3_gpio   = d3_sel == pdm_pkg::CODE_00;
	assign d4_gpio   = d4_sel == pdm_pkg::CODE_00;
	assign d1_serial = d1_sel == pdm_pkg::CODE_11;

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		logic [7:0] pd_in_ok;
		pd_in_ok = 8'h00;
		next_s   = s;
		// Bus write: either half may come first
		if (aw_fire) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = awaddr[7:0];
		end
		if (w_fire) begin
			next_s.w_held  = 1'b1;
			next_s.w_data  = wdata[7:0];
			next_s.w_strb0 = wstrb[0];
		end
		if (wr_go) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = wr_hit ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
			if (wr_hit && wr_strb) begin
				case (wr_addr)
					pdm_pkg::ADDR_FUNC_SEL_LOW:  next_s.func_sel_low = wr_byte;
					pdm_pkg::ADDR_FUNC_SEL_HIGH: next_s.func_sel_high = wr_byte;
					pdm_pkg::ADDR_SRC_SEL_A:     next_s.src_a = wr_byte;
					pdm_pkg::ADDR_SRC_SEL_B:     next_s.src_b = wr_byte;
					pdm_pkg::ADDR_SRC_SEL_C:     next_s.src_c = wr_byte;
					pdm_pkg::ADDR_SRC_SEL_D:     next_s.src_d = wr_byte;
					default: begin
						// Any byte but the key closes the self-test mode again
						next_s.unlock           = wr_byte;
						next_s.read_port_enable = wr_byte == pdm_pkg::UNLOCK_KEY;
					end
				endcase
			end
		end else if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		// Bus read, answered one cycle after the address is taken
		if (ar_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd_hit_data[7:0];
			next_s.rresp  = rd_hit_data[8] ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
		end else if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		// Port D drive; the self-test mode is not looked at here
		case (d3_sel)
			pdm_pkg::CODE_00: {next_s.pd_out[3], next_s.pd_oe[3]} = {gpio_d_out[3], gpio_d_oe[3]};
			pdm_pkg::CODE_01: {next_s.pd_out[3], next_s.pd_oe[3]} = {timer_out1, 1'b1};
			pdm_pkg::CODE_10: {next_s.pd_out[3], next_s.pd_oe[3]} = {hall_out_a, 1'b1};
			default:          {next_s.pd_out[3], next_s.pd_oe[3]} = {gate_a_low, 1'b1};
		endcase
		case (d2_sel)
			pdm_pkg::CODE_00: {next_s.pd_out[2], next_s.pd_oe[2]} = {gpio_d_out[2], gpio_d_oe[2]};
			pdm_pkg::CODE_01: {next_s.pd_out[2], next_s.pd_oe[2]} = {timer_out1_n, 1'b1};
			pdm_pkg::CODE_10: {next_s.pd_out[2], next_s.pd_oe[2]} = {hall_out_b, 1'b1};
			default:          {next_s.pd_out[2], next_s.pd_oe[2]} = {gate_a_high, 1'b1};
		endcase
		case (d1_sel)
			pdm_pkg::CODE_00: {next_s.pd_out[1], next_s.pd_oe[1]} = {gpio_d_out[1], gpio_d_oe[1]};
			pdm_pkg::CODE_01: {next_s.pd_out[1], next_s.pd_oe[1]} = {timer_out0, 1'b1};
			pdm_pkg::CODE_10: {next_s.pd_out[1], next_s.pd_oe[1]} = {hall_out_c, 1'b1};
			default:          {next_s.pd_out[1], next_s.pd_oe[1]} = {serial_out, serial_oe};
		endcase
		case (d4_sel)
			pdm_pkg::CODE_00: {next_s.pd_out[4], next_s.pd_oe[4]} = {gpio_d_out[4], gpio_d_oe[4]};
			pdm_pkg::CODE_01: {next_s.pd_out[4], next_s.pd_oe[4]} = {timer_out2_n, 1'b1};
			pdm_pkg::CODE_10: {next_s.pd_out[4], next_s.pd_oe[4]} = {timer_out1, 1'b1};
			default:          {next_s.pd_out[4], next_s.pd_oe[4]} = {gate_b_high, 1'b1};
		endcase
		// A port D pin feeds a peripheral input only while its general purpose function is selected; port_d1 also feeds the serial input in its serial function
		pd_in_ok[1] = port_d_in[1] && d1_gpio;
		pd_in_ok[2] = port_d_in[2] && d2_gpio;
		pd_in_ok[3] = port_d_in[3] && d3_gpio;
		pd_in_ok[4] = port_d_in[4] && d4_gpio;
		// Input routing; reserved codes hold the input low
		next_s.hall_in[2] = route4(s.src_a[pdm_pkg::F_HI +: 2], port_a_in[5], port_b_in[1],
			port_b_in[5], port_a_in[5]);
		next_s.hall_in[1] = route4(s.src_a[pdm_pkg::F_MH +: 2], port_a_in[4], port_b_in[2],
			port_b_in[6], port_a_in[4]);
		next_s.hall_in[0] = route4(s.src_a[pdm_pkg::F_ML +: 2], port_a_in[3], port_b_in[3],
			1'b0, port_a_in[3]);
		next_s.capture_timer_in = route4(s.src_a[pdm_pkg::F_LO +: 2], port_a_in[6], port_b_in[4],
			1'b0, 1'b0);
		next_s.sda_in = s.src_b[pdm_pkg::F_SDA] ? 1'b0 : port_a_in[7];
		next_s.scl_in = s.src_b[pdm_pkg::F_SCL] ? port_b_in[5] : 1'b0;
		next_s.serial_rx_in = route4(s.src_b[pdm_pkg::F_MH +: 2], 1'b0, port_d_in[1] && d1_serial,
			port_a_in[7], port_b_in[4]);
		next_s.noise_filter_in = route4(s.src_b[pdm_pkg::F_ML +: 2], port_a_in[7], port_a_in[0],
			pd_in_ok[2], 1'b0);
		next_s.ext_irq_in = route4(s.src_b[pdm_pkg::F_LO +: 2], port_a_in[7], pd_in_ok[1],
			port_a_in[2], 1'b0);
		next_s.timer_cap_in[0] = route4(s.src_c[pdm_pkg::F_HI +: 2], port_a_in[0], pd_in_ok[3],
			1'b0, port_a_in[0]);
		next_s.timer_cap_in[1] = route4(s.src_c[pdm_pkg::F_MH +: 2], port_a_in[2], pd_in_ok[2],
			1'b0, port_a_in[2]);
		next_s.timer_cap_in[2] = route4(s.src_c[pdm_pkg::F_ML +: 2], port_b_in[2], pd_in_ok[1],
			1'b0, port_b_in[2]);
		next_s.timer_cap_in[3] = route4(s.src_c[pdm_pkg::F_LO +: 2], port_b_in[1], 1'b0,
			pd_in_ok[4], port_b_in[1]);
		next_s.timer_clk_in[0] = route4(s.src_d[pdm_pkg::F_HI +: 2], port_a_in[7], pd_in_ok[3],
			1'b0, port_b_in[6]);
		next_s.timer_clk_in[1] = route4(s.src_d[pdm_pkg::F_MH +: 2], port_a_in[6], pd_in_ok[2],
			1'b0, port_a_in[6]);
		next_s.timer_clk_in[2] = route4(s.src_d[pdm_pkg::F_ML +: 2], port_b_in[3], pd_in_ok[1],
			1'b0, port_b_in[3]);
		next_s.timer_clk_in[3] = route4(s.src_d[pdm_pkg::F_LO +: 2], 1'b0, 1'b0,
			pd_in_ok[4], 1'b0);
		// Read-back path, per bit of the port being read
		for (int i = 0; i < 8; i++) begin
			if (s.read_port_enable)
				next_s.read_data[i] = rd_pin_level[i];
			else if (rd_is_analog[i])
				next_s.read_data[i] = 1'b0;
			else if (rd_port_ctrl[i])
				next_s.read_data[i] = rd_is_dig_out[i] ? 1'b0 : rd_pin_level[i];
			else
				next_s.read_data[i] = rd_data_latch[i];
		end
		// Analog switches: own function, or forced for the chosen channel in self-test
		for (int c = 0; c < pdm_pkg::AN_CHANNELS; c++) begin
			next_s.an_switch[c] = an_func_sel[c] ||
				(s.read_port_enable && adc_channel_sel == 4'(c));
		end
	end

	// ********************************************************************
	// State register
	// ********************************************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			s <= '0;
		else
			s <= next_s;
	end

	// Outputs straight from the state
	assign bvalid           = s.bvalid;
	assign bresp            = s.bresp;
	assign rvalid           = s.rvalid;
	assign rresp            = s.rresp;
	assign rdata            = {24'h000000, s.rdata};
	assign pd_out           = s.pd_out;
	assign pd_oe            = s.pd_oe;
	assign hall_in1         = s.hall_in[0];
	assign hall_in2         = s.hall_in[1];
	assign hall_in3         = s.hall_in[2];
	assign capture_timer_in = s.capture_timer_in;
	assign sda_in           = s.sda_in;
	assign scl_in           = s.scl_in;
	assign serial_rx_in     = s.serial_rx_in;
	assign noise_filter_in  = s.noise_filter_in;
	assign ext_irq_in       = s.ext_irq_in;
	assign timer_cap_in     = s.timer_cap_in;
	assign timer_clk_in     = s.timer_clk_in;
	assign read_data        = s.read_data;
	assign read_port_enable = s.read_port_enable;
	assign an_switch        = s.an_switch;

	// ********************************************************************
	// Checks
	// ********************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	chk_unlock_key: assert property (
		wr_go && wr_hit && wr_strb && wr_addr == pdm_pkg::ADDR_UNLOCK
		|=> read_port_enable == ($past(wr_byte) == pdm_pkg::UNLOCK_KEY))
		else $error("read_port_enable does not follow unlock byte");
	chk_d3_gate_low: assert property (
		d3_sel == pdm_pkg::CODE_11 |=> pd_oe[3] && pd_out[3] == $past(gate_a_low))
		else $error("port_d3 not driven by gate_a_low");
	chk_d2_timer_n: assert property (
		d2_sel == pdm_pkg::CODE_01 |=> pd_oe[2] && pd_out[2] == $past(timer_out1_n))
		else $error("port_d2 not driven by timer_out1_n");
	chk_d1_serial: assert property (
		d1_serial |=> pd_out[1] == $past(serial_out) && pd_oe[1] == $past(serial_oe))
		else $error("port_d1 not driven by serial port");
	chk_d4_timer: assert property (
		d4_sel == pdm_pkg::CODE_10 |=> pd_oe[4] && pd_out[4] == $past(timer_out1))
		else $error("port_d4 not driven by timer_out1");
	chk_hall3_route: assert property (
		s.src_a[pdm_pkg::F_HI +: 2] == pdm_pkg::CODE_10 |=> hall_in3 == $past(port_b_in[5]))
		else $error("hall_in3 not taken from port_b5");
	chk_hall1_reserved: assert property (
		s.src_a[pdm_pkg::F_ML +: 2] == pdm_pkg::CODE_10 |=> !hall_in1)
		else $error("hall_in1 active on reserved code");
	chk_read_pins: assert property (
		read_port_enable |=> read_data == $past(rd_pin_level))
		else $error("read-back does not return pin levels");
	chk_read_analog: assert property (
		!read_port_enable && rd_is_analog[0] |=> !read_data[0])
		else $error("analog pin reads nonzero while disabled");
	chk_an_forced: assert property (
		read_port_enable && adc_channel_sel == 4'h3 |=> an_switch[3])
		else $error("selected converter switch not forced closed");
	chk_bresp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");

endmodule

// File: tb/pdm_top_tb_top.sv
// Self-checking bench for the port D pin mux, input routing and read-back block
`timescale 1ns/1ps

module pdm_top_tb_top;
	// ********************************************************************
	// Signals
	// ********************************************************************
	logic        mclk, arst_n;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb, cap, tclk, adc;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	logic [7:0]  pa, pb, rpl, rdl, rpc, ran, rdo, read_data;
	logic [4:1]  pdi, go, goe, pd_out, pd_oe;
	logic        t0, t1, t1n, t2n, ha, hb, hc, gal, gah, gbh, so, soe;
	logic        h1, h2, h3, cti, sda, scl, srx, nf, irq, rpe;
	logic [9:0]  anf, answ;
	logic [7:0]  regv [7];
	int          errors, cmp_count, seed;

	pdm_top i_pdm_top (
		.mclk(mclk), .arst_n(arst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.port_a_in(pa), .port_b_in(pb), .port_d_in(pdi), .gpio_d_out(go), .gpio_d_oe(goe),
		.timer_out0(t0), .timer_out1(t1), .timer_out1_n(t1n), .timer_out2_n(t2n),
		.hall_out_a(ha), .hall_out_b(hb), .hall_out_c(hc),
		.gate_a_low(gal), .gate_a_high(gah), .gate_b_high(gbh), .serial_out(so), .serial_oe(soe),
		.pd_out(pd_out), .pd_oe(pd_oe), .hall_in1(h1), .hall_in2(h2), .hall_in3(h3),
		.capture_timer_in(cti), .sda_in(sda), .scl_in(scl), .serial_rx_in(srx),
		.noise_filter_in(nf), .ext_irq_in(irq), .timer_cap_in(cap), .timer_clk_in(tclk),
		.rd_pin_level(rpl), .rd_data_latch(rdl), .rd_port_ctrl(rpc), .rd_is_analog(ran),
		.rd_is_dig_out(rdo), .read_data(read_data), .read_port_enable(rpe),
		.adc_channel_sel(adc), .an_func_sel(anf), .an_switch(answ)
	);

	// Free-running 200 MHz clock
	always #2.5 mclk = ~mclk;

	// ********************************************************************
	// Checking and bus tasks
	// ********************************************************************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Upper data bits carry junk on purpose: only the low byte may land
	task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		awaddr <= {24'h0, a};
		wdata <= {24'hA5A5A5, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				check("bresp", bresp, er);
				bready <= 1'b0;
				break;
			end
			if (++n > 200) begin
				errors++;
				report_and_stop();
			end
		end
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				check("rdata", rdata, {24'h0, exp});
				check("rresp", rresp, er);
				rready <= 1'b0;
				break;
			end
			if (++n > 200) begin
				errors++;
				report_and_stop();
			end
		end
	endtask

	// Fresh random levels on every pin-side input
	task automatic shake_pins();
		@(posedge mclk);
		{pa, pb, pdi, go, goe} <= 28'($random(seed));
		{t0, t1, t1n, t2n, ha, hb, hc, gal, gah, gbh, so, soe} <= 12'($random(seed));
		{rpl, rdl, rpc, ran} <= $random(seed);
		{rdo, adc, anf} <= 22'($random(seed));
	endtask

	function automatic logic sel(input logic [1:0] k, input logic v0, v1, v2, v3);
		logic [3:0] v;
		v = {v3, v2, v1, v0};
		return v[k];
	endfunction

	// ********************************************************************
	// Reference model of the routing, drive and read-back paths
	// ********************************************************************
	task automatic check_outputs();
		logic [7:0] fl, fh, a, b, c, d;
		logic       e;
		logic [4:1] g;
		fl = regv[0];
		fh = regv[1];
		a = regv[2];
		b = regv[3];
		c = regv[4];
		d = regv[5];
		e = (regv[6] === pdm_pkg::UNLOCK_KEY);
		// Port D pins reach peripheral inputs only in their plain function, except port_d1, which feeds the serial input in its serial function
		g = {fh[1:0] == 0 & pdi[4], fl[7:6] == 0 & pdi[3], fl[5:4] == 0 & pdi[2], fl[3:2] == 0 & pdi[1]};
		check("pd_out", pd_out, {sel(fh[1:0], go[4], t2n, t1, gbh), sel(fl[7:6], go[3], t1, ha, gal),
			sel(fl[5:4], go[2], t1n, hb, gah), sel(fl[3:2], go[1], t0, hc, so)});
		check("pd_oe", pd_oe, {sel(fh[1:0], goe[4], 1'b1, 1'b1, 1'b1), sel(fl[7:6], goe[3], 1'b1, 1'b1, 1'b1),
			sel(fl[5:4], goe[2], 1'b1, 1'b1, 1'b1), sel(fl[3:2], goe[1], 1'b1, 1'b1, soe)});
		check("hall", {h3, h2, h1, cti}, {sel(a[7:6], pa[5], pb[1], pb[5], pa[5]), sel(a[5:4], pa[4], pb[2], pb[6], pa[4]),
			sel(a[3:2], pa[3], pb[3], 1'b0, pa[3]), sel(a[1:0], pa[6], pb[4], 1'b0, 1'b0)});
		check("src_b", {sda, scl, srx, nf, irq}, {~b[7] & pa[7], b[6] & pb[5],
			sel(b[5:4], 1'b0, (fl[3:2] == 3) & pdi[1], pa[7], pb[4]), sel(b[3:2], pa[7], pa[0], g[2], 1'b0),
			sel(b[1:0], pa[7], g[1], pa[2], 1'b0)});
		check("cap", cap, {sel(c[1:0], pb[1], 1'b0, g[4], pb[1]), sel(c[3:2], pb[2], g[1], 1'b0, pb[2]),
			sel(c[5:4], pa[2], g[2], 1'b0, pa[2]), sel(c[7:6], pa[0], g[3], 1'b0, pa[0])});
		check("clk", tclk, {sel(d[1:0], 1'b0, 1'b0, g[4], 1'b0), sel(d[3:2], pb[3], g[1], 1'b0, pb[3]),
			sel(d[5:4], pa[6], g[2], 1'b0, pa[6]), sel(d[7:6], pa[7], g[3], 1'b0, pb[6])});
		check("rpe", rpe, e);
		check("read_data", read_data, e ? rpl : ~ran & ((rpc & ~rdo & rpl) | (~rpc & rdl)));
		check("an_switch", answ, anf | ((e && adc < 10) ? 10'h1 << adc : 10'h0));
	endtask

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		mclk = 0;
		arst_n = 0;
		seed = 37;
		errors = 0;
		cmp_count = 0;
		{awaddr, wdata, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
		{pa, pb, pdi, go, goe, rpl, rdl, rpc, ran, rdo, adc, anf} = '0;
		{t0, t1, t1n, t2n, ha, hb, hc, gal, gah, gbh, so, soe} = '0;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		for (int i = 0; i < 7; i++) axi_read(8'(i * 4), 8'h00, 2'h0);
		check("rpe_reset", rpe, 1'b0);
		// Unmapped place: refused, key must not leak into the unlock
		axi_write(8'h1C, pdm_pkg::UNLOCK_KEY, 4'hF, 2'h2);
		axi_read(8'h1C, 8'h00, 2'h2);
		check("rpe_unmapped", rpe, 1'b0);
		for (int i = 0; i < 45; i++) begin
			regv[0] = 8'($random(seed)) & 8'hFC;
			regv[1] = 8'($random(seed)) & 8'h03;
			for (int j = 2; j < 6; j++) regv[j] = 8'($random(seed));
			// Key, key with one bit off, or anything else
			regv[6] = (i % 3 == 0) ? pdm_pkg::UNLOCK_KEY :
				(i % 3 == 1) ? (pdm_pkg::UNLOCK_KEY ^ (8'h1 << (i % 8))) : 8'($random(seed));
			for (int j = 0; j < 7; j++) axi_write(8'(j * 4), regv[j], 4'hF, 2'h0);
			for (int j = 0; j < 7; j++) axi_read(8'(j * 4), regv[j], 2'h0);
			for (int k = 0; k < 4; k++) begin
				shake_pins();
				repeat (3) @(posedge mclk);
				#1;
				check_outputs();
			end
		end
		// Low byte lane off: the write is answered but must not land
		axi_write(pdm_pkg::ADDR_SRC_SEL_A, ~regv[2], 4'hE, 2'h0);
		axi_read(pdm_pkg::ADDR_SRC_SEL_A, regv[2], 2'h0);
		// Second reset in mid-run clears everything again
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		axi_read(pdm_pkg::ADDR_UNLOCK, 8'h00, 2'h0);
		check("rpe_rerst", rpe, 1'b0);
		report_and_stop();
	end
endmodule
